// ==== bench/atic_trim_reg_tb.sv ====
/*
  Self-checking bench for the aging trim and interrupt enable register block.
  Assumes atic_cfg.svh offsets and a one-cycle Wishbone ack.
*/
`timescale 1ns/10ps
`default_nettype none
`include "atic_cfg.svh"

module atic_trim_reg_tb;
  import atic_pkg::*;
  logic               clk_sys;
  logic               reset_n;
  logic               cyc;
  logic               stb;
  logic               we;
  logic [7:0]         adr;
  logic [3:0]         sel;
  logic [31:0]        dat_w;
  logic [31:0]        dat_r;
  logic               ack;
  logic               por_evt;
  logic               vl_evt;
  logic signed [5:0]  trim;
  logic               int_out;
  int                 error_cnt;
  int                 tests_run;
  int                 cyc_cnt;
  atic_byte_type      q;
  int                 vals[3] = '{31, -32, -1};

  atic_trim_reg uut
  (
    .CLK_SYS           (clk_sys),
    .RESET_N           (reset_n),
    .WB_CYC_I          (cyc),
    .WB_STB_I          (stb),
    .WB_WE_I           (we),
    .WB_ADR_I          (adr),
    .WB_SEL_I          (sel),
    .WB_DAT_I          (dat_w),
    .WB_DAT_O          (dat_r),
    .WB_ACK_O          (ack),
    .POR_EVENT         (por_evt),
    .LOW_VOLTAGE_EVENT (vl_evt),
    .AGING_TRIM        (trim),
    .INT_OUT           (int_out)
  );

  always #20 clk_sys = ~clk_sys;

  task stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  always @(posedge clk_sys)
  begin
    cyc_cnt++;
    if (cyc_cnt == 5000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One classic cycle, held until ack is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    sel   <= s;
    dat_w <= {24'h000000, d};
    do @(posedge clk_sys); while (ack !== 1'b1);
    q = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00, 4'hF);
    chk("read", exp, q);
    chk("read_hi", 8'h00, {7'h00, |dat_r[31:8]});
  endtask : rd

  task pulse(input logic lv);
    @(posedge clk_sys);
    if (lv) vl_evt <= 1'b1; else por_evt <= 1'b1;
    repeat (3) @(posedge clk_sys);
    vl_evt  <= 1'b0;
    por_evt <= 1'b0;
  endtask : pulse

  task wait_int(input logic exp);
    int n;
    n = 0;
    while (int_out !== exp && n < 12)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk("int_out", {7'h00, exp}, {7'h00, int_out});
  endtask : wait_int

  initial
  begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h00000000;
    por_evt = 1'b0;
    vl_evt = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    cyc_cnt = 0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(`ATIC_OFS_TRIM, 8'h00);
    rd(`ATIC_OFS_NVM, 8'h00);
    rd(`ATIC_OFS_STATUS, 8'h00);
    foreach (vals[i])
    begin
      wr(`ATIC_OFS_TRIM, 8'(vals[i]) & 8'h3F);
      @(posedge clk_sys);
      chk("trim", {2'b00, 6'(vals[i])}, {2'b00, trim});
      rd(`ATIC_OFS_TRIM, 8'(vals[i]) & 8'h3F);
    end
    xfer(1'b1, `ATIC_OFS_TRIM, 8'hC0, 4'h0);
    rd(`ATIC_OFS_TRIM, 8'h3F);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    wr(`ATIC_OFS_PROTECT, 8'h01);
    wr(`ATIC_OFS_TRIM, 8'h00);
    rd(`ATIC_OFS_TRIM, 8'h3F);
    wr(`ATIC_OFS_PROTECT, 8'h00);
    wr(`ATIC_OFS_TRIM, 8'h80);
    rd(`ATIC_OFS_TRIM, 8'h80);
    pulse(1'b0);
    wait_int(1'b1);
    repeat (10) @(posedge clk_sys);
    wait_int(1'b1);
    wr(`ATIC_OFS_TRIM, 8'h00);
    wait_int(1'b0);
    rd(`ATIC_OFS_STATUS, 8'h01);
    rd(`ATIC_OFS_STATUS, 8'h00);
    pulse(1'b1);
    repeat (8) @(posedge clk_sys);
    wait_int(1'b0);
    rd(`ATIC_OFS_STATUS, 8'h02);
    wr(`ATIC_OFS_TRIM, 8'h40);
    pulse(1'b1);
    wait_int(1'b1);
    repeat (20) @(posedge clk_sys);
    wait_int(1'b1);
    wr(`ATIC_OFS_TRIM, 8'h00);
    wait_int(1'b0);
    rd(`ATIC_OFS_STATUS, 8'h02);
    wr(`ATIC_OFS_MASK, 8'h02);
    rd(`ATIC_OFS_MASK, 8'h02);
    pulse(1'b1);
    wait_int(1'b1);
    rd(`ATIC_OFS_STATUS, 8'h02);
    wait_int(1'b0);
    stop_test();
  end
endmodule : atic_trim_reg_tb

`default_nettype wire

// ==== rtl/atic_cfg.svh ====
/*
  Offsets, field positions, reset values and timing counts of the aging trim
  and interrupt enable register block. Assumes a 25 MHz system clock.
*/
`ifndef ATIC_CFG_SVH
`define ATIC_CFG_SVH

`define ATIC_CLK_HZ            25000000
`define ATIC_REFRESH_MS        66
`define ATIC_REFRESH_CYC       ((`ATIC_REFRESH_MS * `ATIC_CLK_HZ) / 1000)

`define ATIC_OFS_TRIM          8'hC1
`define ATIC_OFS_STATUS        8'hD0
`define ATIC_OFS_MASK          8'hD1
`define ATIC_OFS_PROTECT       8'hD2
`define ATIC_OFS_NVM           8'hD3

`define ATIC_BIT_POWER_ON_EVENT_IRQ_ENABLE         7
`define ATIC_BIT_LOW_VOLTAGE_IRQ_ENABLE          6
`define ATIC_TRIM_MSB          5

`define ATIC_BIT_ST_POR        0
`define ATIC_BIT_ST_VLOW       1
`define ATIC_BIT_ST_LOADED     2

`define ATIC_RST_TRIM          8'h00
`define ATIC_RST_NVM           8'h00
`define ATIC_RST_MASK          8'h00
`define ATIC_RST_PROTECT       1'b0

`endif

// ==== rtl/atic_irq_bit.sv ====
/*
  One held interrupt source: a sticky status bit set by an event and cleared
  by a status read, plus a gated request that stays while enabled and set.
  Assumes synchronous event pulses on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none

module atic_irq_bit
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // Source
  atic_irq_if.bit_side irq
);

  logic sticky_r;

  // Set wins over a read clear in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sticky_r <= 1'b0;
    else if (irq.event_in)
      sticky_r <= 1'b1;
    else if (irq.clear)
      sticky_r <= 1'b0;
  end

  assign irq.sticky  = sticky_r;
  // Request held until cleared; dropping the enable withdraws it
  assign irq.pin_req = sticky_r & irq.enable;

endmodule : atic_irq_bit

`default_nettype wire

// ==== rtl/atic_irq_if.sv ====
/*
  Interface carrying one interrupt source between the main block and the
  sticky interrupt bit module. Assumes one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

interface atic_irq_if;
  logic event_in;
  logic enable;
  logic clear;
  logic sticky;
  logic pin_req;

  modport ctrl
  (
    output event_in,
    output enable,
    output clear,
    input  sticky,
    input  pin_req
  );

  modport bit_side
  (
    input  event_in,
    input  enable,
    input  clear,
    output sticky,
    output pin_req
  );
endinterface : atic_irq_if

`default_nettype wire

// ==== rtl/atic_pkg.sv ====
/*
  Types shared by the aging trim and interrupt enable register block.
  Assumes the constants of atic_cfg.svh.
*/
package atic_pkg;

  typedef logic [7:0] atic_byte_type;

  typedef enum logic [1:0]
  {
    ATIC_WAIT = 2'b00,
    ATIC_LOAD = 2'b01,
    ATIC_RUN  = 2'b10
  } atic_state_type;

endpackage : atic_pkg

// ==== rtl/atic_trim_reg.sv ====
/*
  Aging trim and interrupt enable register with nonvolatile copy and working
  mirror, Wishbone classic slave, interrupt status/mask and level output.
  Assumes power-on and low-voltage detectors outside, async pin inputs.
*/
// Our own choice: the Wishbone interface to the registers.
//
// Function
// - After power-up and the first refresh delay, copy stored value into mirror
// - Stored copy reset value is all zeros: enables cleared, trim zero
// - Register C1h: trim in bits 5:0, bit 6 low-voltage enable, bit 7 power-on enable
// - Bit 7 gates power-on event to interrupt pin; clearing withdraws it; D1h mask bit 0 still passes the power-on status to the pin
// - Low-voltage event asserts pin when enabled; assertion is held
// - Low-voltage enable clear blocks and withdraws the interrupt; D1h mask bit 1 still passes the low-voltage status to the pin
// - Trim is two's complement steps of about 0.23842 ppm each
// - Reads always allowed; C1h and D3h writes blocked while the D2h protect bit is set; D1h and D2h stay writable
`timescale 1ns/10ps
`default_nettype none
`include "atic_cfg.svh"

module atic_trim_reg
(
  // Clock and reset
  input  wire logic               CLK_SYS,
  input  wire logic               RESET_N,
  // Wishbone classic slave
  input  wire logic               WB_CYC_I,
  input  wire logic               WB_STB_I,
  input  wire logic               WB_WE_I,
  input  wire logic [7:0]         WB_ADR_I,
  input  wire logic [3:0]         WB_SEL_I,
  input  wire logic [31:0]        WB_DAT_I,
  output var  logic [31:0]        WB_DAT_O,
  output var  logic               WB_ACK_O,
  // Event detector pins
  input  wire logic               POR_EVENT,
  input  wire logic               LOW_VOLTAGE_EVENT,
  // Results
  output var  logic signed [5:0]  AGING_TRIM,
  output var  logic               INT_OUT
);
  import atic_pkg::*;

  atic_state_type state_r;
  atic_state_type state_nxt;
  logic [31:0]    refresh_cnt_r;
  atic_byte_type  nvm_r;
  atic_byte_type  mirror_r;
  atic_byte_type  mask_r;
  logic           protect_r;
  logic           loaded_r;
  logic           loaded_evt;
  logic           loaded_clr;
  logic [1:0]     por_sync_r;
  logic [1:0]     vl_sync_r;
  logic           por_d_r;
  logic           vl_d_r;
  logic           req;
  logic           wr_ok;
  logic           rd_status;
  logic [7:0]     status;

  atic_irq_if por_if ();
  atic_irq_if vl_if ();

  // Two-stage synchronisers, then edge detection on stage two
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      por_sync_r <= 2'b00;
      vl_sync_r  <= 2'b00;
      por_d_r    <= 1'b0;
      vl_d_r     <= 1'b0;
    end
    else
    begin
      por_sync_r <= {por_sync_r[0], POR_EVENT};
      vl_sync_r  <= {vl_sync_r[0], LOW_VOLTAGE_EVENT};
      por_d_r    <= por_sync_r[1];
      vl_d_r     <= vl_sync_r[1];
    end
  end

  // Bus decode; ack one cycle after request, low for one cycle after
  assign req       = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr_ok     = req & WB_WE_I & WB_SEL_I[0];
  assign rd_status = req & ~WB_WE_I & (WB_ADR_I == `ATIC_OFS_STATUS);

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      WB_ACK_O <= 1'b0;
    else
      WB_ACK_O <= req;
  end

  // Power-up refresh sequence
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ATIC_WAIT: if (refresh_cnt_r == `ATIC_REFRESH_CYC - 1) state_nxt = ATIC_LOAD;
      ATIC_LOAD: state_nxt = ATIC_RUN;
      ATIC_RUN:  state_nxt = ATIC_RUN;
      default:   state_nxt = ATIC_WAIT;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_r       <= ATIC_WAIT;
      refresh_cnt_r <= 32'h00000000;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == ATIC_WAIT)
        refresh_cnt_r <= refresh_cnt_r + 32'h00000001;
    end
  end

  // Stored copy; C1h writes go through to both copies when unprotected (stored copy only in the load cycle), D3h writes to the stored copy only
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      nvm_r <= `ATIC_RST_NVM;
    else if (wr_ok && !protect_r && WB_ADR_I == `ATIC_OFS_NVM)
      nvm_r <= WB_DAT_I[7:0];
    else if (wr_ok && !protect_r && WB_ADR_I == `ATIC_OFS_TRIM)
      nvm_r <= WB_DAT_I[7:0];
  end

  // Working mirror
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      mirror_r <= `ATIC_RST_TRIM;
    else if (state_r == ATIC_LOAD)
      mirror_r <= nvm_r;
    else if (wr_ok && !protect_r && WB_ADR_I == `ATIC_OFS_TRIM)
      mirror_r <= WB_DAT_I[7:0];
  end

  // Mask and write protection
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      mask_r    <= `ATIC_RST_MASK;
      protect_r <= `ATIC_RST_PROTECT;
    end
    else
    begin
      if (wr_ok && WB_ADR_I == `ATIC_OFS_MASK)
        mask_r <= WB_DAT_I[7:0];
      if (wr_ok && WB_ADR_I == `ATIC_OFS_PROTECT)
        protect_r <= WB_DAT_I[0];
    end
  end

  // Mirror-loaded event flag
  assign loaded_evt = (state_r == ATIC_LOAD);
  assign loaded_clr = rd_status;

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      loaded_r <= 1'b0;
    else if (loaded_evt)
      loaded_r <= 1'b1;
    else if (loaded_clr)
      loaded_r <= 1'b0;
  end

  // Interrupt sources
  assign por_if.event_in = por_sync_r[1] & ~por_d_r;
  assign por_if.enable   = mirror_r[`ATIC_BIT_POWER_ON_EVENT_IRQ_ENABLE];
  assign por_if.clear    = rd_status;
  assign vl_if.event_in  = vl_sync_r[1] & ~vl_d_r;
  assign vl_if.enable    = mirror_r[`ATIC_BIT_LOW_VOLTAGE_IRQ_ENABLE];
  assign vl_if.clear     = rd_status;

  atic_irq_bit u_por_bit
  (
    .clk   (CLK_SYS),
    .rst_n (RESET_N),
    .irq   (por_if.bit_side)
  );

  atic_irq_bit u_vl_bit
  (
    .clk   (CLK_SYS),
    .rst_n (RESET_N),
    .irq   (vl_if.bit_side)
  );

  always_comb
  begin
    status = 8'h00;
    status[`ATIC_BIT_ST_POR]    = por_if.sticky;
    status[`ATIC_BIT_ST_VLOW]   = vl_if.sticky;
    status[`ATIC_BIT_ST_LOADED] = loaded_r;
  end

  // Pin: enable-gated held requests, plus masked sticky status
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      INT_OUT <= 1'b0;
    else
      INT_OUT <= por_if.pin_req | vl_if.pin_req | (|(status & mask_r));
  end

  // Trim value as signed step count, about 0.23842 ppm per step
  assign AGING_TRIM = signed'(mirror_r[`ATIC_TRIM_MSB:0]);

  // Read data registered; reads always allowed
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      WB_DAT_O <= 32'h00000000;
    else if (req && !WB_WE_I)
    begin
      case (WB_ADR_I)
        `ATIC_OFS_TRIM:    WB_DAT_O <= {24'h000000, mirror_r};
        `ATIC_OFS_NVM:     WB_DAT_O <= {24'h000000, nvm_r};
        `ATIC_OFS_STATUS:  WB_DAT_O <= {24'h000000, status};
        `ATIC_OFS_MASK:    WB_DAT_O <= {24'h000000, mask_r};
        `ATIC_OFS_PROTECT: WB_DAT_O <= {24'h000000, 7'h00, protect_r};
        default:           WB_DAT_O <= 32'h00000000;
      endcase
    end
  end

  sequence s_load_step;
    state_r == ATIC_LOAD;
  endsequence

  a_mirror_load_copy: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    s_load_step |=> (mirror_r == $past(nvm_r)))
    else $error("mirror not loaded from stored copy");

  a_load_after_wait: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (state_r == ATIC_LOAD) |-> (refresh_cnt_r == `ATIC_REFRESH_CYC))
    else $error("load before refresh delay");

  a_por_gate_off: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    !mirror_r[`ATIC_BIT_POWER_ON_EVENT_IRQ_ENABLE] |-> !por_if.pin_req)
    else $error("power-on request while disabled");

  a_vl_held_pin: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (vl_if.event_in && vl_if.enable) |=> ##1 INT_OUT)
    else $error("low-voltage interrupt not asserted");

  a_vl_gate_off: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (!vl_if.enable && !por_if.pin_req && (status & mask_r) == 8'h00) |=> !INT_OUT)
    else $error("interrupt with sources disabled");

  a_protect_block: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (protect_r && state_r != ATIC_LOAD) |=> $stable(mirror_r))
    else $error("protected register changed");

  a_trim_sign: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    AGING_TRIM[5] == mirror_r[`ATIC_TRIM_MSB])
    else $error("trim sign wrong");

  a_ack_one_cycle: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held too long");

endmodule : atic_trim_reg

`default_nettype wire
